// ### fawp_protect.sv
/*
  Flash access and write protection logic: volatile copies of the four
  one-time-programmable protection registers, the temporary unprotect
  bit, and the per-access verdict for core and event transfer accesses.
  Assumes the nonvolatile cells arrive on nv_* ports and stay stable.
*/
// The implementer's own choice: the plain strobed port.
// What this block does
// - four one-time-programmable protection registers: sector write plus three access
// - sector write-protect bit at 0 blocks all writes to that sector
// - access-protect bit 0 refuses flash data access unless fetched from flash
// - debug-protect bit erased allows debug bypass; programmed disables debug
// - disable bit x at 0 with reenable x at 1 cancels access protect
// - disable bit 0 programmable only after debug and access bits are 0
// - disable bit x programmable only after reenable bit x-1 is 0
// - reenable bit x at 0 with disable x+1 erased restores protection
// - reenable bit x programmable only after disable bit x is 0
// - temporary unprotect bit at 1 suspends access protection
// - temporary unprotect writes ignored unless fetched from flash
// - protected exactly when access bit 0 not cancelled by the disable/reenable chain and temporary bit 0
// - at most sixteen permanent disable then reenable cycles
// - protected flash writes from ram or external memory are discarded
// - protected flash reads from elsewhere return dummy data and trap
// - protected flash blocks event transfer data reads and writes
// - jumps into flash and reads of other memories always allowed
// - protected flash rejects flash control register writes
// - reset forces protections, then loads four volatile copies once
// - set-protection rejected if issued by code fetched from flash, while access protected, or at an unknown address
`timescale 1ns/1ns
`default_nettype none

module fawp_protect (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] nv_sector_write_protect,
  input wire logic [15:0] nv_access_debug_protect,
  input wire logic [15:0] nv_protect_disable_chain,
  input wire logic [15:0] nv_protect_reenable_chain,
  input wire logic fetch_valid,
  input wire fawp_pkg::fawp_src_e fetch_src,
  input wire fawp_pkg::fawp_access_s access,
  output fawp_pkg::fawp_verdict_s verdict,
  input wire fawp_pkg::fawp_setprot_s setprot,
  output logic setprot_accept,
  output logic setprot_reject,
  output logic debug_enable,
  output logic access_protected,
  input wire logic [23:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    fawp_pkg::fawp_state_e state;
    logic [15:0] sector_wp;
    logic [15:0] acc_dbg;
    logic [15:0] protect_disable_bits;
    logic [15:0] protect_reenable_bits;
    logic temp_unprotect;
    fawp_pkg::fawp_src_e exec_src;
    fawp_pkg::fawp_verdict_s verdict;
    logic setprot_accept;
    logic setprot_reject;
    logic [15:0] rdata;
  } fawp_state_s;

  fawp_state_s r;
  fawp_state_s next_r;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic in_range(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [3:0] sector_of(input logic [23:0] a);
    logic [3:0] s;
    s = 4'h9;
    for (int i = fawp_pkg::NUM_SECTORS - 1; i >= 0; i--) begin
      if (a < fawp_pkg::SECTOR_BOUNDARY[i]) begin
        s = 4'(i);
      end
    end
    sector_of = s;
  endfunction

  // set when the disable/reenable chain cancels the access protect bit
  function automatic logic chain_disabled(input logic [15:0] protect_disable_bits, input logic [15:0] protect_reenable_bits);
    logic d;
    d = 1'b0;
    for (int x = 0; x < fawp_pkg::NUM_CHAIN; x++) begin
      if (!protect_disable_bits[x] && protect_reenable_bits[x]) begin
        d = 1'b1;
      end
    end
    chain_disabled = d;
  endfunction

  // ------------------------------------------------------------------
  // protection decision
  // ------------------------------------------------------------------
  logic protected_now;
  logic access_flag;
  logic from_flash;

  always_comb begin
    access_flag = r.acc_dbg[fawp_pkg::ACCESS_PROTECT_POS] ||
                  chain_disabled(r.protect_disable_bits, r.protect_reenable_bits);
    protected_now = !access_flag && !r.temp_unprotect;
    from_flash = (r.exec_src == fawp_pkg::FAWP_SRC_FLASH);
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  logic in_flash;
  logic in_regs;
  logic [3:0] sect;
  logic [15:0] d;
  logic [15:0] ok;

  always_comb begin
    next_r = r;
    in_flash = in_range(access.addr, fawp_pkg::FLASH_BASE, fawp_pkg::FLASH_TOP);
    in_regs = in_range(access.addr, fawp_pkg::FLASH_REG_BASE, fawp_pkg::FLASH_REG_TOP);
    sect = sector_of(access.addr);
    d = setprot.data;
    ok = 16'h0000;
    next_r.verdict = '0;
    next_r.setprot_accept = 1'b0;
    next_r.setprot_reject = 1'b0;
    next_r.rdata = 16'h0000;

    case (r.state)
      fawp_pkg::FAWP_LOAD: begin
        // single read of the cells after reset; forced values held until then
        next_r.sector_wp = nv_sector_write_protect;
        next_r.acc_dbg = nv_access_debug_protect;
        next_r.protect_disable_bits = nv_protect_disable_chain;
        next_r.protect_reenable_bits = nv_protect_reenable_chain;
        next_r.state = fawp_pkg::FAWP_RUN;
      end
      fawp_pkg::FAWP_RUN: begin
        if (fetch_valid) begin
          next_r.exec_src = fetch_src;
        end

        if (access.valid) begin
          next_r.verdict.allow = 1'b1;
          if (access.jump) begin
            next_r.verdict.allow = 1'b1;
          end else if (in_flash) begin
            if (protected_now && (access.event_xfer || !from_flash)) begin
              next_r.verdict.allow = 1'b0;
              if (!access.write) begin
                next_r.verdict.dummy = 1'b1;
                next_r.verdict.trap = !access.event_xfer;
                next_r.verdict.trap_vector = fawp_pkg::PROTECT_TRAP_VECTOR;
              end
            end else if (access.write && !r.sector_wp[sect]) begin
              next_r.verdict.allow = 1'b0;
            end
          end else if (in_regs && access.write && protected_now) begin
            next_r.verdict.allow = 1'b0;
          end
        end

        if (setprot.valid) begin
          // programming only clears bits; the disable and reenable chain bits are guarded by their chain order
          if (from_flash) begin
            next_r.setprot_reject = 1'b1;
          end else if (protected_now) begin
            // control registers locked, so no set-protection can start yet
            next_r.setprot_reject = 1'b1;
          end else if (setprot.addr == fawp_pkg::NV_SECTOR_WRITE_PROTECT_ADDR) begin
            next_r.sector_wp = r.sector_wp & d;
            next_r.setprot_accept = 1'b1;
          end else if (setprot.addr == fawp_pkg::NV_ACCESS_DEBUG_PROTECT_ADDR) begin
            next_r.acc_dbg = r.acc_dbg & d;
            next_r.setprot_accept = 1'b1;
          end else if (setprot.addr == fawp_pkg::NV_PROTECT_DISABLE_CHAIN_ADDR) begin
            ok[0] = !r.acc_dbg[fawp_pkg::ACCESS_PROTECT_POS] &&
                    !r.acc_dbg[fawp_pkg::DEBUG_PROTECT_POS];
            for (int x = 1; x < fawp_pkg::NUM_CHAIN; x++) begin
              ok[x] = !r.protect_reenable_bits[x-1];
            end
            next_r.protect_disable_bits = r.protect_disable_bits & (d | ~ok);
            next_r.setprot_accept = 1'b1;
            next_r.setprot_reject = |(~d & ~ok & r.protect_disable_bits);
          end else if (setprot.addr == fawp_pkg::NV_PROTECT_REENABLE_CHAIN_ADDR) begin
            ok = ~r.protect_disable_bits;
            next_r.protect_reenable_bits = r.protect_reenable_bits & (d | ~ok);
            next_r.setprot_accept = 1'b1;
            next_r.setprot_reject = |(~d & ~ok & r.protect_reenable_bits);
          end else begin
            next_r.setprot_reject = 1'b1;
          end
        end

        if (reg_write && reg_addr == fawp_pkg::TEMP_ACCESS_UNPROTECT_ADDR && from_flash) begin
          next_r.temp_unprotect = reg_wdata[fawp_pkg::TEMP_UNPROTECT_POS];
        end
      end
      default: begin
        next_r.state = fawp_pkg::FAWP_LOAD;
      end
    endcase

    if (reg_read) begin
      if (reg_addr == fawp_pkg::NV_SECTOR_WRITE_PROTECT_ADDR) begin
        next_r.rdata = r.sector_wp;
      end else if (reg_addr == fawp_pkg::NV_ACCESS_DEBUG_PROTECT_ADDR) begin
        next_r.rdata = r.acc_dbg;
      end else if (reg_addr == fawp_pkg::NV_PROTECT_DISABLE_CHAIN_ADDR) begin
        next_r.rdata = r.protect_disable_bits;
      end else if (reg_addr == fawp_pkg::NV_PROTECT_REENABLE_CHAIN_ADDR) begin
        next_r.rdata = r.protect_reenable_bits;
      end else if (reg_addr == fawp_pkg::TEMP_ACCESS_UNPROTECT_ADDR) begin
        next_r.rdata = {15'h0, r.temp_unprotect};
      end else if (reg_addr == fawp_pkg::PROTECT_STATUS_ADDR) begin
        next_r.rdata = {13'h0, (r.state == fawp_pkg::FAWP_RUN), from_flash, protected_now};
      end else begin
        next_r.rdata = 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      r.state <= fawp_pkg::FAWP_LOAD;
      r.sector_wp <= fawp_pkg::FORCED_PROTECT;
      r.acc_dbg <= fawp_pkg::FORCED_PROTECT;
      r.protect_disable_bits <= fawp_pkg::NV_CHAIN_ERASED;
      r.protect_reenable_bits <= fawp_pkg::FORCED_PROTECT;
      r.temp_unprotect <= fawp_pkg::TEMP_ACCESS_UNPROTECT_RESET[0];
      r.exec_src <= fawp_pkg::FAWP_SRC_EXT;
      r.verdict <= '0;
      r.setprot_accept <= 1'b0;
      r.setprot_reject <= 1'b0;
      r.rdata <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign verdict = r.verdict;
  assign setprot_accept = r.setprot_accept;
  assign setprot_reject = r.setprot_reject;
  // forced low while loading so debug cannot slip through at reset
  assign debug_enable = (r.state == fawp_pkg::FAWP_RUN) &&
                        r.acc_dbg[fawp_pkg::DEBUG_PROTECT_POS];
  assign access_protected = protected_now;
  assign reg_rdata = r.rdata;

endmodule

`default_nettype wire

// ### fawp_pkg.sv
/*
  Package for the flash access and write protection block: register
  offsets, field positions, reset values, access source codes and the
  carrier structs shared by the design and its surroundings.
  Assumes a 10 MHz system clock and a synchronous active-high reset.
*/
package fawp_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ------------------------------------------------------------------
  localparam logic [23:0] NV_ACCESS_DEBUG_PROTECT_ADDR = 24'h08dfb8;
  localparam logic [23:0] NV_PROTECT_DISABLE_CHAIN_ADDR = 24'h08dfbc;
  localparam logic [23:0] NV_SECTOR_WRITE_PROTECT_ADDR = 24'h08dfb4;
  localparam logic [23:0] NV_PROTECT_REENABLE_CHAIN_ADDR = 24'h08dfbe;
  localparam logic [23:0] TEMP_ACCESS_UNPROTECT_ADDR = 24'h0e0000;
  localparam logic [23:0] PROTECT_STATUS_ADDR = 24'h0e0002;

  // ------------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------------
  localparam int ACCESS_PROTECT_POS = 0;
  localparam int DEBUG_PROTECT_POS = 1;
  localparam int TEMP_UNPROTECT_POS = 0;
  localparam int NUM_SECTORS = 10;
  localparam int NUM_CHAIN = 16;
  localparam logic [15:0] NV_ACCESS_DEBUG_PROTECT_RESET = 16'hacff;
  localparam logic [15:0] NV_CHAIN_ERASED = 16'hffff;
  // all protections forced while the cells are not yet loaded
  localparam logic [15:0] FORCED_PROTECT = 16'h0000;
  localparam logic [15:0] TEMP_ACCESS_UNPROTECT_RESET = 16'h0000;
  localparam logic [15:0] PROTECT_TRAP_VECTOR = 16'h009b;
  localparam logic [15:0] DUMMY_READ_DATA = 16'hffff;

  // flash address window and flash control register window
  localparam logic [23:0] FLASH_BASE = 24'h000000;
  localparam logic [23:0] FLASH_TOP = 24'h03ffff;
  localparam logic [23:0] FLASH_REG_BASE = 24'h080000;
  localparam logic [23:0] FLASH_REG_TOP = 24'h08ffff;
  localparam logic [23:0] SECTOR_BOUNDARY [10] = '{24'h002000, 24'h004000,
    24'h006000, 24'h008000, 24'h010000, 24'h018000, 24'h020000, 24'h028000,
    24'h030000, 24'h038000};

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    FAWP_SRC_FLASH = 2'b00,
    FAWP_SRC_INTERNAL_RAM = 2'b01,
    FAWP_SRC_EXTENSION_RAM = 2'b10,
    FAWP_SRC_EXT = 2'b11
  } fawp_src_e;

  typedef enum logic [1:0] {
    FAWP_LOAD = 2'b00,
    FAWP_RUN = 2'b01
  } fawp_state_e;

  // data access from the core or the event transfer unit
  typedef struct packed {
    logic valid;
    logic write;
    logic jump;
    logic event_xfer;
    logic [23:0] addr;
  } fawp_access_s;

  typedef struct packed {
    logic allow;
    logic dummy;
    logic trap;
    logic [15:0] trap_vector;
  } fawp_verdict_s;

  // set-protection request from the program sequencer
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [15:0] data;
  } fawp_setprot_s;

endpackage

// ### fawp_protect_props.sv
/*
  Checker for the flash protection block: properties on the top ports.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module fawp_protect_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] nv_sector_write_protect,
  input wire logic fetch_valid,
  input wire fawp_pkg::fawp_src_e fetch_src,
  input wire fawp_pkg::fawp_access_s access,
  input wire fawp_pkg::fawp_verdict_s verdict,
  input wire fawp_pkg::fawp_setprot_s setprot,
  input wire logic setprot_accept,
  input wire logic setprot_reject,
  input wire logic debug_enable,
  input wire logic access_protected,
  input wire logic [23:0] reg_addr,
  input wire logic reg_write
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  fawp_pkg::fawp_src_e src_q;
  logic req;
  logic fl;
  logic ext;
  assign req = access.valid && !access.jump;
  assign fl = access.addr <= fawp_pkg::FLASH_TOP;
  assign ext = access_protected && src_q != fawp_pkg::FAWP_SRC_FLASH;

  // mirror of the executing source, not visible at the ports otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      src_q <= fawp_pkg::FAWP_SRC_EXT;
    end else if (fetch_valid) begin
      src_q <= fetch_src;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);

  property p_rd_trap; req && !access.write && !access.event_xfer && fl && ext |=>
    !verdict.allow && verdict.dummy && verdict.trap && verdict.trap_vector == 16'h009b; endproperty
  a_rd_trap: assert property (p_rd_trap) else $error("protected read not trapped");
  property p_wr_drop; req && access.write && fl && ext |=> !verdict.allow; endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("protected write let through");
  property p_rd_ok; req && !access.write && !access.event_xfer && fl &&
    src_q == fawp_pkg::FAWP_SRC_FLASH |=> verdict.allow; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read from flash code refused");
  property p_jump; access.valid && access.jump |=> verdict.allow; endproperty
  a_jump: assert property (p_jump) else $error("jump refused");
  property p_pec; req && access.event_xfer && fl && access_protected |=>
    !verdict.allow && !verdict.trap; endproperty
  a_pec: assert property (p_pec) else $error("event transfer let through");
  property p_regwr; req && access.write && access.addr >= fawp_pkg::FLASH_REG_BASE &&
    access.addr <= fawp_pkg::FLASH_REG_TOP && access_protected |=> !verdict.allow; endproperty
  a_regwr: assert property (p_regwr) else $error("register write let through");
  property p_sector0; req && access.write && access.addr < fawp_pkg::SECTOR_BOUNDARY[0] &&
    !nv_sector_write_protect[0] |=> !verdict.allow; endproperty
  a_sector0: assert property (p_sector0) else $error("sector write let through");
  property p_spflash; setprot.valid && src_q == fawp_pkg::FAWP_SRC_FLASH |=>
    setprot_reject && !setprot_accept; endproperty
  a_spflash: assert property (p_spflash) else $error("set protection from flash");
  property p_temp; reg_write && reg_addr == fawp_pkg::TEMP_ACCESS_UNPROTECT_ADDR && ext &&
    !setprot.valid |=> access_protected; endproperty
  a_temp: assert property (p_temp) else $error("unprotect from outside flash");
  property p_forced; $fell(reset) |-> access_protected && !debug_enable; endproperty
  a_forced: assert property (p_forced) else $error("not forced during reset");
  property p_spprot; setprot.valid && access_protected |=>
    setprot_reject && !setprot_accept; endproperty
  a_spprot: assert property (p_spprot) else $error("set protection while protected");

  c_trap: cover property (verdict.trap);
  c_accept: cover property (setprot_accept);
  c_refuse: cover property (setprot_reject);
  c_unprot: cover property ($fell(access_protected));
endmodule

bind fawp_protect fawp_protect_props i_props (.clk(clk), .reset(reset),
  .nv_sector_write_protect(nv_sector_write_protect), .fetch_valid(fetch_valid),
  .fetch_src(fetch_src), .access(access), .verdict(verdict), .setprot(setprot),
  .setprot_accept(setprot_accept), .setprot_reject(setprot_reject),
  .debug_enable(debug_enable), .access_protected(access_protected),
  .reg_addr(reg_addr), .reg_write(reg_write));
`default_nettype wire

// ### fawp_core_model.sv
/*
  Model of the core and event transfer unit: announces the source of
  each executed instruction and issues one-cycle data accesses.
  Assumes the block samples on the rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none

module fawp_core_model (
  input wire logic clk,
  output var logic fetch_valid,
  output var fawp_pkg::fawp_src_e fetch_src,
  output var fawp_pkg::fawp_access_s access
);
  initial begin
    fetch_valid = 1'b0;
    fetch_src = fawp_pkg::FAWP_SRC_EXT;
    access = '0;
  end

  // source is announced before any access that it qualifies
  task automatic exec(input fawp_pkg::fawp_src_e s);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_src <= s;
    @(posedge clk);
    fetch_valid <= 1'b0;
  endtask

  // released address is inverted so a stale value never looks valid
  task automatic acc(input logic w, j, e, input logic [23:0] a);
    @(posedge clk);
    access <= {1'b1, w, j, e, a};
    @(posedge clk);
    access <= {4'h0, ~a};
  endtask
endmodule
`default_nettype wire

// ### fawp_protect_test.sv
/*
  Self-checking bench for the flash protection block: register, access
  and set-protection sequences with expected verdicts.
  Assumes the package, the block, the core model and the checker.
*/
`timescale 1ns/1ns
`default_nettype none

module fawp_protect_test;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [23:0] TMP = fawp_pkg::TEMP_ACCESS_UNPROTECT_ADDR;
  localparam logic [23:0] DIS = fawp_pkg::NV_PROTECT_DISABLE_CHAIN_ADDR;
  localparam logic [23:0] REN = fawp_pkg::NV_PROTECT_REENABLE_CHAIN_ADDR;
  logic clk, reset, fetch_valid, setprot_accept, setprot_reject;
  logic debug_enable, access_protected, reg_write, reg_read;
  logic [15:0] nv_wp, nv_ad, nv_pd, nv_pe, reg_wdata, reg_rdata;
  logic [23:0] reg_addr;
  fawp_pkg::fawp_src_e fetch_src;
  fawp_pkg::fawp_access_s access;
  fawp_pkg::fawp_verdict_s verdict;
  fawp_pkg::fawp_setprot_s setprot;
  int err_count, cmp_count, cyc;

  fawp_protect i_dut (.clk(clk), .reset(reset), .nv_sector_write_protect(nv_wp),
    .nv_access_debug_protect(nv_ad), .nv_protect_disable_chain(nv_pd),
    .nv_protect_reenable_chain(nv_pe), .fetch_valid(fetch_valid), .fetch_src(fetch_src),
    .access(access), .verdict(verdict), .setprot(setprot), .setprot_accept(setprot_accept),
    .setprot_reject(setprot_reject), .debug_enable(debug_enable),
    .access_protected(access_protected), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  fawp_core_model i_core (.clk(clk), .fetch_valid(fetch_valid), .fetch_src(fetch_src),
    .access(access));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [23:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask

  // verdict compared as {allow, dummy, trap}
  task automatic ac(input logic w, j, e, input logic [23:0] a, input logic [2:0] x,
    input string n);
    i_core.acc(w, j, e, a);
    #1 chk(n, {13'h0, x}, {13'h0, verdict.allow, verdict.dummy, verdict.trap});
  endtask

  task automatic sp(input logic [23:0] a, input logic [15:0] d, input logic ak, rj, pr);
    @(posedge clk);
    setprot <= {1'b1, a, d};
    @(posedge clk);
    setprot <= {1'b0, ~a, ~d};
    #1 chk("accept", {15'h0, ak}, {15'h0, setprot_accept});
    chk("reject", {15'h0, rj}, {15'h0, setprot_reject});
    chk("protected", {15'h0, pr}, {15'h0, access_protected});
  endtask

  // ------------------------------------------------------------------
  // clock, timeout and sequence
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the sequence needs some 120 cycles; twenty-five times that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      close_out;
    end
  end

  initial begin
    reset = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    setprot = '0;
    nv_wp = 16'hfffe;
    nv_ad = 16'hacfc;
    nv_pd = 16'hffff;
    nv_pe = 16'hffff;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("protected", 16'h0001, {15'h0, access_protected});
    chk("debug", 16'h0000, {15'h0, debug_enable});
    rd(fawp_pkg::NV_ACCESS_DEBUG_PROTECT_ADDR, 16'hacfc, "apr");
    rd(fawp_pkg::NV_SECTOR_WRITE_PROTECT_ADDR, 16'hfffe, "wpr");
    rd(fawp_pkg::PROTECT_STATUS_ADDR, 16'h0005, "status");
    rd(24'h0e0010, 16'h0000, "unmapped");
    ac(0, 0, 0, 24'h001000, 3'b011, "ext read");
    chk("vector", 16'h009b, verdict.trap_vector);
    ac(1, 0, 0, 24'h003000, 3'b000, "ext write");
    ac(0, 1, 0, 24'h001000, 3'b100, "jump");
    ac(0, 0, 0, 24'h0f0000, 3'b100, "other read");
    ac(0, 0, 0, 24'h080000, 3'b100, "reg read");
    ac(1, 0, 1, 24'h001000, 3'b000, "pec write");
    ac(1, 0, 0, 24'h080000, 3'b000, "reg write");
    wr(TMP, 16'h0001);
    rd(TMP, 16'h0000, "temp ignored");
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    rd(fawp_pkg::PROTECT_STATUS_ADDR, 16'h0007, "status flash");
    ac(0, 0, 0, 24'h001000, 3'b100, "flash read");
    ac(1, 0, 0, 24'h080000, 3'b000, "flash reg write");
    wr(TMP, 16'h0001);
    #1 chk("unprotected", 16'h0000, {15'h0, access_protected});
    ac(1, 0, 0, 24'h001000, 3'b000, "sector 0");
    ac(1, 0, 0, 24'h003000, 3'b100, "sector 1");
    ac(1, 0, 1, 24'h003000, 3'b100, "pec open");
    ac(1, 0, 0, 24'h080000, 3'b100, "reg open");
    sp(fawp_pkg::NV_SECTOR_WRITE_PROTECT_ADDR, 16'hfffd, 1'b0, 1'b1, 1'b0);
    wr(TMP, 16'h0000);
    #1 chk("restored", 16'h0001, {15'h0, access_protected});
    i_core.exec(fawp_pkg::FAWP_SRC_INTERNAL_RAM);
    sp(DIS, 16'hfffe, 1'b0, 1'b1, 1'b1);
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0001);
    i_core.exec(fawp_pkg::FAWP_SRC_EXT);
    sp(DIS, 16'hfffe, 1'b1, 1'b0, 1'b0);
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0000);
    #1 chk("disabled", 16'h0000, {15'h0, access_protected});
    i_core.exec(fawp_pkg::FAWP_SRC_EXT);
    sp(REN, 16'hfffd, 1'b1, 1'b1, 1'b0);
    sp(REN, 16'hfffe, 1'b1, 1'b0, 1'b1);
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0001);
    i_core.exec(fawp_pkg::FAWP_SRC_EXT);
    sp(DIS, 16'hfffb, 1'b1, 1'b1, 1'b0);
    sp(DIS, 16'hfffd, 1'b1, 1'b0, 1'b0);
    rd(DIS, 16'hfffc, "pds");
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0000);
    #1 chk("disabled again", 16'h0000, {15'h0, access_protected});
    // second reset with erased debug and access cells
    @(posedge clk);
    nv_ad <= 16'hacff;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("debug open", 16'h0001, {15'h0, debug_enable});
    chk("open", 16'h0000, {15'h0, access_protected});
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0001);
    i_core.exec(fawp_pkg::FAWP_SRC_EXTENSION_RAM);
    sp(fawp_pkg::NV_ACCESS_DEBUG_PROTECT_ADDR, 16'hfffc, 1'b1, 1'b0, 1'b0);
    chk("debug shut", 16'h0000, {15'h0, debug_enable});
    sp(24'h0e0010, 16'h0000, 1'b0, 1'b1, 1'b0);
    i_core.exec(fawp_pkg::FAWP_SRC_FLASH);
    wr(TMP, 16'h0000);
    #1 chk("protect on", 16'h0001, {15'h0, access_protected});
    close_out;
  end
endmodule
`default_nettype wire
